// ### verilog/draw_engine_param_regs.v
// Purpose: APB register bank and command sequencer of a 2D drawing engine.
// Assumes: APB4 slave, 32-bit data, pstrb for byte access, one clock.
// Notes:   Drawing itself is reduced to one pixel step per clock.
//
// Decided for this implementation: the APB register port.
`include "draw_engine_param_regs_defines.vh"

module draw_engine_param_regs #(
   parameter SLOTS = 8,
   parameter SLOT_BITS = 3
) (
   input wire clock,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg engine_busy,
   output reg pixel_write,
   output reg [2:0] pixel_dir,
   output reg [2:0] command_type,
   output reg across_plane,
   output reg radial_dir,
   output reg wait_host_data,
   output reg [1:0] bus_size,
   output reg byte_swap,
   output reg [2:0] trap_dir,
   output reg [13:0] y_param,
   output reg [13:0] x_param,
   output reg [31:0] write_mask,
   output reg [31:0] read_mask,
   output reg [31:0] compare_value
);

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   // Merges the byte lanes selected by the strobes into an old value.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   // Shows a 14-bit field as a step (line) or a 12-bit coordinate.
   function [13:0] coord_or_step;
      input [13:0] value;
      input is_line;
      begin
         if (is_line) begin
            coord_or_step = value;
         end else begin
            coord_or_step = {2'b00, value[11:0]};
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   localparam ST_IDLE = 2'b00; // Engine waits for a queued command.
   localparam ST_RUN = 2'b01; // Engine steps through pixels.
   localparam ST_VEC2 = 2'b10; // Engine runs second short-stroke vector.
   reg [15:0] sys_config; // Bit 0 enables the engine registers.
   reg [11:0] current_x; // Current horizontal coordinate.
   reg [11:0] current_x_second; // Second horizontal coordinate.
   reg [13:0] dest_y_axial_step; // End Y or axial step.
   reg [13:0] dest_y_axial_step_second; // Second end Y or step.
   reg [13:0] dest_x_diag_step; // End X or diagonal step.
   reg [11:0] extra_x_coord; // Extra X for multipoint commands.
   reg [13:0] line_error_term; // Initial line decision value.
   reg [13:0] trapezoid_error_term; // Trapezoid decision value.
   reg [11:0] major_axis_count; // Longest axis length minus one.
   reg [11:0] major_axis_count_second; // Second long axis length.
   reg [15:0] draw_command_second; // Second command word.
   reg [31:0] back_colour; // Background colour.
   reg [31:0] fore_colour; // Foreground colour.
   reg [15:0] back_mix_select; // Background mix selection.
   reg [16:0] queue [0:SLOTS-1]; // Command slots: {stroke, word}.
   reg [SLOT_BITS-1:0] wr_ptr; // Next slot to fill.
   reg [SLOT_BITS-1:0] rd_ptr; // Next slot to run.
   reg [SLOT_BITS:0] pending; // Number of filled slots.
   reg [1:0] state; // Engine sequencer state.
   reg [12:0] steps; // Pixel steps left in this pass.
   reg draw_on; // Pixels of this pass are written.
   reg [7:0] vector_two; // Second short-stroke vector.
   reg [16:0] head; // Slot at the read pointer.
   reg [12:0] next_steps; // Step count for a starting command.
   reg head_was_stroke; // Running command came from a short stroke.

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   wire [15:0] index = paddr[17:2]; // Register index from byte address.
   wire enabled = sys_config[`CFG_ENABLE_BIT]; // Engine registers live.
   wire access = psel & penable & ~pready; // Access phase, not yet answered.
   wire commit = psel & penable & pready; // Edge where a transfer completes.
   wire do_write = commit & pwrite & enabled & ~pslverr;
   wire [12:0] free_slots = SLOTS[12:0] - {{(12-SLOT_BITS){1'b0}}, pending};
   wire full = (pending == SLOTS[SLOT_BITS:0]); // No slot free.
   wire pop = (state == ST_IDLE) & (pending != 0); // Engine takes a slot.
   wire finishing = (steps == 0) & // Last step of the command taken.
      ((state == ST_VEC2) | (state == ST_RUN & ~head_was_stroke));
   reg mapped; // Index names a register.
   reg [31:0] read_value; // Read data before it is registered.
   reg [31:0] held_value; // Current word that byte writes merge into.
   wire [31:0] merged = merge(held_value, pwdata, pstrb); // Written word.
   wire [15:0] status_word = {free_slots[12:8], (pending == 0), engine_busy,
      1'b0, free_slots[7:0]};
   // A full queue drops the command; the host polls free slots first.
   wire push_cmd = do_write & (index == `IDX_STATUS_CMD) & ~full;
   wire push_stroke = do_write & (index == `IDX_SHORT_STROKE) & ~full;
   // Decodes the index and builds the read value.
   always @* begin
      mapped = 1'b1;
      read_value = `RST_ZERO32;
      case (index)
         `IDX_SYS_CONFIG: read_value = {16'h0000, sys_config};
         `IDX_CURRENT_X: read_value = {20'h00000, current_x};
         `IDX_CURRENT_X_SECOND: read_value = {20'h00000, current_x_second};
         `IDX_DEST_Y: read_value = {18'h00000, dest_y_axial_step};
         `IDX_DEST_Y_SECOND:
            read_value = {18'h00000, dest_y_axial_step_second};
         `IDX_DEST_X: read_value = {18'h00000, dest_x_diag_step};
         `IDX_EXTRA_X: read_value = {20'h00000, extra_x_coord};
         `IDX_LINE_ERR: read_value = {18'h00000, line_error_term};
         `IDX_TRAP_ERR: read_value = {18'h00000, trapezoid_error_term};
         `IDX_MAJOR_COUNT: read_value = {20'h00000, major_axis_count};
         `IDX_MAJOR_COUNT_SECOND:
            read_value = {20'h00000, major_axis_count_second};
         `IDX_STATUS_CMD: read_value = {16'h0000, status_word};
         `IDX_CMD_SECOND: read_value = `RST_ZERO32;
         `IDX_SHORT_STROKE: read_value = `RST_ZERO32;
         `IDX_BACK_COLOUR: read_value = back_colour;
         `IDX_FORE_COLOUR: read_value = fore_colour;
         `IDX_WRITE_MASK: read_value = write_mask;
         `IDX_READ_MASK: read_value = read_mask;
         `IDX_COMPARE: read_value = compare_value;
         `IDX_BACK_MIX: read_value = `RST_ZERO32;
         default: mapped = 1'b0;
      endcase
      // Write-only words keep their own value as the base of a byte write.
      held_value = (index == `IDX_CMD_SECOND) ?
         {16'h0000, draw_command_second} : (index == `IDX_BACK_MIX) ?
         {16'h0000, back_mix_select} : read_value;
      // Disabled engine registers read as zero; configuration stays open.
      if (!enabled && index != `IDX_SYS_CONFIG) begin
         read_value = `RST_ZERO32;
      end
   end

   // ------------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------------
   // Answers one cycle into the access phase, data and error registered.
   always @(posedge clock) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `RST_ZERO32;
      end else begin
         pready <= access;
         pslverr <= access & ~mapped; // Error stands with ready only.
         if (access) begin
            prdata <= pwrite ? `RST_ZERO32 : read_value;
         end
      end
   end

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------
   // Stores written lanes; byte or word writes via the strobes.
   always @(posedge clock) begin
      if (sys_rst) begin
         sys_config <= `RST_ZERO16;
         current_x <= 12'h000;
         current_x_second <= 12'h000;
         dest_y_axial_step <= 14'h0000;
         dest_y_axial_step_second <= 14'h0000;
         dest_x_diag_step <= 14'h0000;
         extra_x_coord <= 12'h000;
         line_error_term <= 14'h0000;
         trapezoid_error_term <= 14'h0000;
         major_axis_count <= 12'h000;
         major_axis_count_second <= 12'h000;
         draw_command_second <= `RST_ZERO16;
         back_colour <= `RST_ZERO32;
         fore_colour <= `RST_ZERO32;
         write_mask <= `RST_ZERO32;
         read_mask <= `RST_ZERO32;
         compare_value <= `RST_ZERO32;
         back_mix_select <= `RST_ZERO16;
      end else begin
         // Configuration is reachable even while the engine is off.
         if (commit & pwrite & (index == `IDX_SYS_CONFIG)) begin
            sys_config <= merged[15:0];
         end
         if (do_write) begin
            case (index)
               `IDX_CURRENT_X: current_x <= merged[11:0];
               `IDX_CURRENT_X_SECOND: current_x_second <= merged[11:0];
               `IDX_DEST_Y: dest_y_axial_step <= merged[13:0];
               `IDX_DEST_Y_SECOND: dest_y_axial_step_second <= merged[13:0];
               `IDX_DEST_X: dest_x_diag_step <= merged[13:0];
               `IDX_EXTRA_X: extra_x_coord <= merged[11:0];
               `IDX_LINE_ERR: line_error_term <= merged[13:0];
               `IDX_TRAP_ERR: trapezoid_error_term <= merged[13:0];
               `IDX_MAJOR_COUNT: major_axis_count <= merged[11:0];
               `IDX_MAJOR_COUNT_SECOND:
                  major_axis_count_second <= merged[11:0];
               `IDX_CMD_SECOND: draw_command_second <= merged[15:0];
               `IDX_BACK_COLOUR: back_colour <= merged;
               `IDX_FORE_COLOUR: fore_colour <= merged;
               `IDX_WRITE_MASK: write_mask <= merged;
               `IDX_READ_MASK: read_mask <= merged;
               `IDX_COMPARE: compare_value <= merged;
               `IDX_BACK_MIX: back_mix_select <= merged[15:0];
               default: ;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Command queue
   // ------------------------------------------------------------------
   // Holds queued commands in order; push and pop may share a cycle.
   always @(posedge clock) begin
      if (sys_rst) begin
         wr_ptr <= {SLOT_BITS{1'b0}};
         rd_ptr <= {SLOT_BITS{1'b0}};
         pending <= {(SLOT_BITS+1){1'b0}};
      end else begin
         if (push_cmd | push_stroke) begin
            queue[wr_ptr] <= {push_stroke, pwdata[15:0]};
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if ((push_cmd | push_stroke) & ~pop) begin
            pending <= pending + 1'b1;
         end else if (pop & ~(push_cmd | push_stroke)) begin
            pending <= pending - 1'b1;
         end
      end
   end

   // Works out the step count of the command at the head.
   always @* begin
      head = queue[rd_ptr];
      if (head[16]) begin
         next_steps = {9'h000, head[3:0]} + 13'h0001;
      end else if (head[`CMD_NOLAST_BIT]) begin
         next_steps = {1'b0, major_axis_count};
      end else begin
         next_steps = {1'b0, major_axis_count} + 13'h0001;
      end
   end

   // ------------------------------------------------------------------
   // Engine sequencer
   // ------------------------------------------------------------------
   // Runs one pixel step per clock; busy spans accept to final step.
   always @(posedge clock) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         steps <= 13'h0000;
         draw_on <= 1'b0;
         vector_two <= 8'h00;
         engine_busy <= 1'b0;
         pixel_write <= 1'b0;
         pixel_dir <= 3'h0;
         command_type <= 3'h0;
         across_plane <= 1'b0;
         radial_dir <= 1'b0;
         wait_host_data <= 1'b0;
         bus_size <= 2'h0;
         byte_swap <= 1'b0;
         trap_dir <= 3'h0;
         y_param <= 14'h0000;
         x_param <= 14'h0000;
         head_was_stroke <= 1'b0;
      end else begin
         pixel_write <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (pop) begin
                  steps <= next_steps;
                  draw_on <= head[`CMD_DRAW_BIT];
                  pixel_dir <= head[`CMD_DIR_LSB +: 3];
                  vector_two <= head[15:8];
                  head_was_stroke <= head[16];
                  state <= ST_RUN;
                  if (!head[16]) begin
                     command_type <= head[`CMD_TYPE_LSB +: 3];
                     across_plane <= head[`CMD_ACROSS_BIT];
                     radial_dir <= head[`CMD_RADIAL_BIT];
                     wait_host_data <= head[`CMD_WAIT_BIT];
                     bus_size <= head[`CMD_BUS_LSB +: 2];
                     byte_swap <= head[`CMD_SWAP_BIT];
                     trap_dir <= draw_command_second[7:5];
                     y_param <= coord_or_step(dest_y_axial_step,
                        head[15:13] == `CMD_TYPE_LINE);
                     x_param <= coord_or_step(dest_x_diag_step,
                        head[15:13] == `CMD_TYPE_LINE);
                  end
               end
            end
            ST_RUN, ST_VEC2: begin
               if (steps != 0) begin
                  pixel_write <= draw_on;
                  steps <= steps - 13'h0001;
               end else if (state == ST_RUN && head_was_stroke) begin
                  steps <= {9'h000, vector_two[3:0]} + 13'h0001;
                  draw_on <= vector_two[4];
                  pixel_dir <= vector_two[7:5];
                  state <= ST_VEC2;
               end else begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
         // Busy on the accept edge and until the engine returns idle.
         engine_busy <= push_cmd | push_stroke | (pending != 0) |
            ((state != ST_IDLE) & ~finishing);
      end
   end

endmodule

// ### verilog/draw_engine_param_regs_defines.vh
// Purpose: Offsets, field positions and reset values of the drawing
//          engine parameter registers.
// Assumes: Offsets are register indices; byte address is index times four.
// Notes:   Definitions only.
`ifndef DRAW_ENGINE_PARAM_REGS_DEFINES_VH
`define DRAW_ENGINE_PARAM_REGS_DEFINES_VH

// ------------------------------------------------------------------
// Register indices
// ------------------------------------------------------------------
`define IDX_SYS_CONFIG 16'h0000
`define IDX_CURRENT_X 16'h86e8
`define IDX_CURRENT_X_SECOND 16'h86ea
`define IDX_DEST_Y 16'h8ae8
`define IDX_DEST_Y_SECOND 16'h8aea
`define IDX_DEST_X 16'h8ee8
`define IDX_EXTRA_X 16'h8eea
`define IDX_LINE_ERR 16'h92e8
`define IDX_TRAP_ERR 16'h92ea
`define IDX_MAJOR_COUNT 16'h96e8
`define IDX_MAJOR_COUNT_SECOND 16'h96ea
`define IDX_STATUS_CMD 16'h9ae8
`define IDX_CMD_SECOND 16'h9aea
`define IDX_SHORT_STROKE 16'h9ee8
`define IDX_BACK_COLOUR 16'ha2e8
`define IDX_FORE_COLOUR 16'ha6e8
`define IDX_WRITE_MASK 16'haae8
`define IDX_READ_MASK 16'haee8
`define IDX_COMPARE 16'hb2e8
`define IDX_BACK_MIX 16'hb6e8

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CFG_ENABLE_BIT 0
`define ST_BUSY_BIT 9
`define ST_EMPTY_BIT 10
`define CMD_ACROSS_BIT 1
`define CMD_NOLAST_BIT 2
`define CMD_RADIAL_BIT 3
`define CMD_DRAW_BIT 4
`define CMD_DIR_LSB 5
`define CMD_WAIT_BIT 8
`define CMD_BUS_LSB 9
`define CMD_SWAP_BIT 12
`define CMD_TYPE_LSB 13
`define CMD_TYPE_LINE 3'h1

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_ZERO16 16'h0000
`define RST_ZERO32 32'h00000000

`endif

// ### verification/draw_engine_param_regs_properties.sv
// Purpose: Assertions on the APB and engine ports of the register bank.
// Assumes: One clock, synchronous reset, registered one-wait answer.
// Notes:   Bound to every instance of the bank.
`include "draw_engine_param_regs_defines.vh"
module draw_engine_param_regs_properties #(
   parameter SLOTS = 8
) (
   input wire clock,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire engine_busy,
   input wire pixel_write,
   input wire [31:0] write_mask
);
   // ------------------------------------------------------------
   // Helper logic and properties
   // ------------------------------------------------------------
   wire [15:0] idx = paddr[17:2];
   wire wr = psel && penable && pready && pwrite;
   reg cfg_en; // Enable bit as software last wrote it.
   // Track the enable so register checks apply only when it is on.
   always @(posedge clock) begin
      if (sys_rst)
         cfg_en <= 1'b0;
      else if (wr && idx == `IDX_SYS_CONFIG && pstrb[0])
         cfg_en <= pwdata[0];
   end
   sequence s_start;
      psel && !penable ##1 psel && penable;
   endsequence
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_ready_wait: assert property (s_start |-> !pready ##1 pready)
      else $error("answer not one cycle into the access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("read data not zero on a write");
   a_status_fields: assert property (pready && psel && !pwrite &&
      idx == `IDX_STATUS_CMD |-> prdata[31:16] == 16'h0 &&
      prdata[15:11] == 5'h0 && !prdata[8] && prdata[7:0] <= SLOTS)
      else $error("status fields out of range");
   a_busy_start: assert property (wr && cfg_en && !engine_busy &&
      idx == `IDX_STATUS_CMD |=> engine_busy)
      else $error("busy not raised after a command");
   a_pix_busy: assert property (pixel_write |-> engine_busy)
      else $error("pixel step while idle");
   a_mask_update: assert property (wr && cfg_en && pstrb == 4'hf &&
      idx == `IDX_WRITE_MASK |=> write_mask == $past(pwdata))
      else $error("write mask not updated");
endmodule
bind draw_engine_param_regs draw_engine_param_regs_properties #(
   .SLOTS(SLOTS)) draw_engine_param_regs_properties_inst (.clock,
   .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
   .pready, .pslverr, .engine_busy, .pixel_write, .write_mask);

// ### verification/apb_host.sv
// Purpose: Host model that issues APB transfers to the register bank.
// Assumes: Its tasks are entered just after a rising clock edge.
// Notes:   The bus idles one cycle between transfers.
`include "draw_engine_param_regs_defines.vh"
module apb_host (
   input wire clock,
   input wire pready,
   input wire pslverr,
   input wire [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [17:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Transfers
   // ------------------------------------------------------------
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // Setup cycle, then access until ready; released address and write data are inverted.
   task automatic xfer(input logic w, input logic [17:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge clock);
   endtask
   // Drawing command; the lowest bit is always sent as one.
   task automatic cmd(input logic [15:0] c);
      logic [31:0] r;
      logic e;
      xfer(1'b1, {`IDX_STATUS_CMD, 2'b00}, {16'h0, c | 16'h1},
         4'h3, r, e);
   endtask
endmodule

// ### verification/draw_engine_param_regs_tb.sv
// Purpose: Self-checking bench for the drawing engine register bank.
// Assumes: Host model drives APB; SLOTS is eight.
// Notes:   Pixel steps are counted on pixel_write pulses.
`include "draw_engine_param_regs_defines.vh"
module draw_engine_param_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, engine_busy, pixel_write;
   logic across_plane, radial_dir, wait_host_data, byte_swap, er;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, write_mask, read_mask, compare_value, rd;
   logic [3:0] pstrb;
   logic [2:0] pixel_dir, command_type, trap_dir;
   logic [1:0] bus_size;
   logic [13:0] y_param, x_param;
   logic [15:0] c, c2, dy, dx;
   logic [31:0] rv [0:14];
   logic [15:0] ridx [0:14] = '{`IDX_CURRENT_X, `IDX_CURRENT_X_SECOND,
      `IDX_DEST_Y, `IDX_DEST_Y_SECOND, `IDX_DEST_X, `IDX_EXTRA_X,
      `IDX_LINE_ERR, `IDX_TRAP_ERR, `IDX_MAJOR_COUNT,
      `IDX_MAJOR_COUNT_SECOND, `IDX_BACK_COLOUR, `IDX_FORE_COLOUR,
      `IDX_WRITE_MASK, `IDX_READ_MASK, `IDX_COMPARE};
   logic [31:0] rmsk [0:14] = '{32'hfff, 32'hfff, 32'h3fff, 32'h3fff,
      32'h3fff, 32'hfff, 32'h3fff, 32'h3fff, 32'hfff, 32'hfff, '1, '1, '1,
      '1, '1};
   integer miscompares = 0, num_checks = 0, seed = 32'h5dac3c44, pix = 0;
   integer i, n, base;
   // ------------------------------------------------------------
   // Clock, instances and helpers
   // ------------------------------------------------------------
   initial forever #10 clock = ~clock;
   draw_engine_param_regs #(.SLOTS(8), .SLOT_BITS(3))
      draw_engine_param_regs_inst (.clock, .sys_rst, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .engine_busy, .pixel_write, .pixel_dir, .command_type, .across_plane,
      .radial_dir, .wait_host_data, .bus_size, .byte_swap, .trap_dir,
      .y_param, .x_param, .write_mask, .read_mask, .compare_value);
   apb_host apb_host_inst (.clock, .pready, .pslverr, .prdata, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb);
   // Counts drawn pixel steps.
   always @(posedge clock) if (pixel_write === 1'b1) pix <= pix + 1;
   // Pixel steps a command should draw.
   function automatic integer steps(input integer k, input logic skip, d);
      return d ? k + 1 - skip : 0;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [15:0] ix, input logic [31:0] d,
      input logic [3:0] s);
      apb_host_inst.xfer(1'b1, {ix, 2'b00}, d, s, rd, er);
   endtask
   task automatic rdr(input logic [15:0] ix);
      apb_host_inst.xfer(1'b0, {ix, 2'b00}, 32'h0, 4'h0, rd, er);
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 2000 && engine_busy !== 1'b0; k++)
         @(posedge clock);
      chk("idle", engine_busy, 1'b0);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Watchdog far beyond the few hundred cycles the tests need.
   initial begin
      #400000;
      miscompares++;
      finish_test;
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      wr(`IDX_READ_MASK, 32'h12345678, 4'hf);
      rdr(`IDX_READ_MASK);
      chk("disabled read", rd, 32'h0);
      wr(`IDX_SYS_CONFIG, 32'h1, 4'h1);
      rdr(`IDX_STATUS_CMD);
      chk("idle status", rd, 32'h0408);
      $display("test enable done");
      for (i = 0; i < 15; i++) begin
         rv[i] = $random(seed);
         wr(ridx[i], rv[i], 4'hf);
         rdr(ridx[i]);
         chk("register", rd, rv[i] & rmsk[i]);
      end
      chk("write mask", write_mask, rv[12]);
      chk("read mask", read_mask, rv[13]);
      wr(`IDX_COMPARE, 32'haabbccdd, 4'h4);
      chk("compare", compare_value, rv[14] & 32'hff00ffff | 32'hbb0000);
      rdr(16'h1234);
      chk("unmapped error", er, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("test registers done");
      for (i = 0; i < 3; i++) begin
         n = $random(seed) & 7;
         dy = $random(seed);
         dx = $random(seed);
         c = $random(seed);
         c2 = $random(seed);
         c[15:13] = (i == 2) ? 3'h2 : `CMD_TYPE_LINE;
         c[4] = (i != 2);
         c[2] = (i == 1);
         wr(`IDX_MAJOR_COUNT, n, 4'h3);
         wr(`IDX_DEST_Y, dy, 4'h3);
         wr(`IDX_DEST_X, dx, 4'h3);
         wr(`IDX_CMD_SECOND, c2, 4'h3);
         base = pix;
         apb_host_inst.cmd(c);
         wait_idle;
         chk("pixels", pix - base, steps(n, c[2], c[4]));
         chk("type", command_type, c[15:13]);
         chk("fields", {across_plane, radial_dir, wait_host_data, bus_size,
            byte_swap}, {c[1], c[3], c[8], c[10:9], c[12]});
         chk("trap dir", trap_dir, c2[7:5]);
         chk("dir", pixel_dir, c[7:5]);
         chk("y", y_param, (i == 2) ? dy[11:0] : dy[13:0]);
         chk("x", x_param, (i == 2) ? dx[11:0] : dx[13:0]);
      end
      wr(`IDX_MAJOR_COUNT, 32'd20, 4'h3);
      base = pix;
      apb_host_inst.cmd(16'h2010);
      rdr(`IDX_STATUS_CMD);
      chk("running", rd, 32'h0608);
      apb_host_inst.cmd(16'h2010);
      rdr(`IDX_STATUS_CMD);
      chk("queued", rd, 32'h0207);
      wait_idle;
      chk("two commands", pix - base, 42);
      c = $random(seed);
      c[4] = 1'b1;
      base = pix;
      wr(`IDX_SHORT_STROKE, c, 4'h3);
      wait_idle;
      chk("stroke", pix - base,
         c[3:0] + 1 + steps(c[11:8], 0, c[12]));
      chk("stroke dir", pixel_dir, c[15:13]);
      $display("test engine done");
      finish_test;
   end
endmodule
